//--- design/dtiom_pkg.sv
package dtiom_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 4;
	localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
	// Filter update period, equal to the 0.01 s unit of the time constant
	localparam int FILT_STEP_US  = 10000;
	localparam int FILT_STEP_CYC = FILT_STEP_US * 1000 / CLK_PERIOD_NS;
	// Up/down rate counts 0.01 Hz steps per second
	localparam int UPDN_S_CYC    = CLK_HZ;

	// Field widths
	localparam int VOLT_W = 11;   // 0.01 V or 0.01 mA units
	localparam int PCT_W  = 12;   // signed, 0.1 % units
	localparam int FREQ_W = 16;   // 0.01 Hz units
	localparam int RATE_W = 13;   // 0.01 Hz/s units
	localparam int TC_W   = 10;   // 0.01 s units
	localparam int SEL_W  = 4;
	localparam int FUNC_W = 5;

	// Full-scale points
	localparam logic [VOLT_W-1:0]        VOLT_FULL = 11'h3e8;
	localparam logic signed [PCT_W-1:0]  PCT_FULL  = 12'h3e8;

	// Values after reset
	localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;
	localparam logic [VOLT_W-1:0] FILT_RST = 11'h000;

	// Terminal wiring modes
	typedef enum logic [1:0] {
		MODE_2W_DIR = 2'h0,
		MODE_2W_EN  = 2'h1,
		MODE_3W_DIR = 2'h2,
		MODE_3W_EN  = 2'h3
	} dtiom_mode_t;

	// Run command states
	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_FWD  = 3'b010,
		ST_REV  = 3'b100
	} dtiom_run_t;

	// Digital input function codes
	localparam logic [FUNC_W-1:0] FUNC_FWD = 5'h01;
	localparam logic [FUNC_W-1:0] FUNC_REV = 5'h02;
	localparam logic [FUNC_W-1:0] FUNC_3W  = 5'h03;
	localparam logic [FUNC_W-1:0] FUNC_UP  = 5'h09;
	localparam logic [FUNC_W-1:0] FUNC_DN  = 5'h0a;
	localparam logic [FUNC_W-1:0] FUNC_CLR = 5'h0b;

	// Digital and relay output selector codes
	localparam logic [SEL_W-1:0] OSEL_NONE  = 4'h0;
	localparam logic [SEL_W-1:0] OSEL_FREQ  = 4'h1;
	localparam logic [SEL_W-1:0] OSEL_DET   = 4'h2;
	localparam logic [SEL_W-1:0] OSEL_FAULT = 4'h3;
	localparam logic [SEL_W-1:0] OSEL_FWD   = 4'h4;
	localparam logic [SEL_W-1:0] OSEL_REV   = 4'h5;
	localparam logic [SEL_W-1:0] OSEL_NULL  = 4'h6;
	localparam logic [SEL_W-1:0] OSEL_UPPER = 4'h7;
	localparam logic [SEL_W-1:0] OSEL_LOWER = 4'h8;

	// Analog output source codes
	localparam logic [SEL_W-1:0] AOS_SETF   = 4'h0;
	localparam logic [SEL_W-1:0] AOS_OPERF  = 4'h1;
	localparam logic [SEL_W-1:0] AOS_CURR   = 4'h2;
	localparam logic [SEL_W-1:0] AOS_VOLT   = 4'h3;
	localparam logic [SEL_W-1:0] AOS_SPEED  = 4'h4;
	localparam logic [SEL_W-1:0] AOS_POWER  = 4'h5;
	localparam logic [SEL_W-1:0] AOS_TORQUE = 4'h6;
	localparam logic [SEL_W-1:0] AOS_VIN    = 4'h7;
	localparam logic [SEL_W-1:0] AOS_CIN    = 4'h8;

endpackage

//--- design/dtiom_scale.sv
`timescale 1ns/1ns
// Linear two-point map with clamping, one cycle of latency
module dtiom_scale #(
	parameter int XW = 12,
	parameter int YW = 12
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_b,
	input  wire logic signed [XW-1:0] i_x,
	input  wire logic signed [XW-1:0] i_x_lo,
	input  wire logic signed [XW-1:0] i_x_hi,
	input  wire logic signed [YW-1:0] i_y_lo,
	input  wire logic signed [YW-1:0] i_y_hi,
	output logic signed [YW-1:0]      o_y
);

	logic signed [YW-1:0] y_r;
	logic signed [YW-1:0] y_nxt;
	logic signed [31:0]   prod;

	if (XW < 2 || YW < 2 || XW > 14 || YW > 14) begin : g_chk
		$error("dtiom_scale: width out of range");
	end

	// Outside the points the level clamps; equal points never divide
	always_comb begin
		prod = 32'(i_x - i_x_lo) * 32'(i_y_hi - i_y_lo);
		if (i_x <= i_x_lo) begin
			y_nxt = i_y_lo;
		end else if (i_x >= i_x_hi) begin
			y_nxt = i_y_hi;
		end else begin
			y_nxt = YW'(32'(i_y_lo) + prod / 32'(i_x_hi - i_x_lo));
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			y_r <= '0;
		end else begin
			y_r <= y_nxt;
		end
	end

	assign o_y = y_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	property p_clamp_low;
		(i_x <= i_x_lo) |=> (y_r == $past(i_y_lo));
	endproperty
	a_clamp_low: assert property (p_clamp_low)
		else $error("scaler did not clamp to lower level");

	property p_clamp_high;
		(i_x >= i_x_hi && i_x > i_x_lo) |=> (y_r == $past(i_y_hi));
	endproperty
	a_clamp_high: assert property (p_clamp_high)
		else $error("scaler did not clamp to upper level");

endmodule

//--- design/dtiom_top.sv
`timescale 1ns/1ns
module dtiom_top #(
	parameter int NTERM    = 6,
	parameter int FILT_CYC = dtiom_pkg::FILT_STEP_CYC,
	parameter int SEC_CYC  = dtiom_pkg::UPDN_S_CYC
) (
	input  wire logic                              i_clk,
	input  wire logic                              i_rst_b,
	input  wire logic [NTERM-1:0]                  i_term,
	input  wire logic [NTERM*dtiom_pkg::FUNC_W-1:0] i_term_func,
	input  wire logic [1:0]                        i_mode,
	input  wire logic                              i_ext_stop,
	input  wire logic [dtiom_pkg::RATE_W-1:0]      i_updn_rate,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_max_freq,
	input  wire logic [2*dtiom_pkg::VOLT_W-1:0]    i_ain_level,
	input  wire logic [1:0]                        i_ain_current_mode,
	input  wire logic [2*dtiom_pkg::VOLT_W-1:0]    i_ain_lo,
	input  wire logic [2*dtiom_pkg::VOLT_W-1:0]    i_ain_hi,
	input  wire logic [2*dtiom_pkg::PCT_W-1:0]     i_ain_lo_set,
	input  wire logic [2*dtiom_pkg::PCT_W-1:0]     i_ain_hi_set,
	input  wire logic [2*dtiom_pkg::TC_W-1:0]      i_ain_filt_tc,
	input  wire logic                              i_freq_reached,
	input  wire logic                              i_det_reached,
	input  wire logic                              i_fault,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_out_freq,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_start_freq,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_upper_freq,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_lower_freq,
	input  wire logic [3*dtiom_pkg::SEL_W-1:0]     i_dout_sel,
	input  wire logic [dtiom_pkg::SEL_W-1:0]       i_ao_sel,
	input  wire logic                              i_ao_current_mode,
	input  wire logic [dtiom_pkg::PCT_W-1:0]       i_ao_lo_pct,
	input  wire logic [dtiom_pkg::PCT_W-1:0]       i_ao_hi_pct,
	input  wire logic [dtiom_pkg::VOLT_W-1:0]      i_ao_lo_lvl,
	input  wire logic [dtiom_pkg::VOLT_W-1:0]      i_ao_hi_lvl,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_out_current,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_out_voltage,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_speed,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_power,
	input  wire logic [dtiom_pkg::FREQ_W-1:0]      i_torque,
	output logic                                   o_run_fwd,
	output logic                                   o_run_rev,
	output logic [dtiom_pkg::FREQ_W-1:0]           o_set_freq,
	output logic [2*dtiom_pkg::PCT_W-1:0]          o_ain_setting,
	output logic [2:0]                             o_dout,
	output logic [dtiom_pkg::VOLT_W:0]             o_analog_output
);

	localparam int VW = dtiom_pkg::VOLT_W;
	localparam int PW = dtiom_pkg::PCT_W;
	localparam int FW = dtiom_pkg::FREQ_W;
	localparam int SW = dtiom_pkg::SEL_W;

	if (NTERM < 3 || NTERM > 16 || FILT_CYC < 1 || SEC_CYC < 5000) begin : g_chk
		$error("dtiom_top: parameter out of range");
	end

	// Three-stage sampling of terminals; a level counts once the last two stages agree
	logic [NTERM-1:0] s1_r, s2_r, s3_r, st_r, st_nxt;
	logic [NTERM-1:0] m_fwd, m_rev, m_en, m_up, m_dn, m_clr;

	always_comb begin
		st_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & st_r);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			st_r <= '0;
		end else begin
			s1_r <= i_term;
			s2_r <= s1_r;
			s3_r <= s2_r;
			st_r <= st_nxt;
		end
	end

	// Per-terminal function decode builds a mask for each role
	for (genvar t = 0; t < NTERM; t++) begin : g_func
		logic [dtiom_pkg::FUNC_W-1:0] fn;
		assign fn       = i_term_func[t*dtiom_pkg::FUNC_W +: dtiom_pkg::FUNC_W];
		assign m_fwd[t] = (fn == dtiom_pkg::FUNC_FWD);
		assign m_rev[t] = (fn == dtiom_pkg::FUNC_REV);
		assign m_en[t]  = (fn == dtiom_pkg::FUNC_3W);
		assign m_up[t]  = (fn == dtiom_pkg::FUNC_UP);
		assign m_dn[t]  = (fn == dtiom_pkg::FUNC_DN);
		assign m_clr[t] = (fn == dtiom_pkg::FUNC_CLR);
	end

	logic fwd_s, rev_s, en_s, up_s, dn_s, clr_s;
	assign fwd_s = |(st_r & m_fwd);
	assign rev_s = |(st_r & m_rev);
	assign en_s  = |(st_r & m_en);
	assign up_s  = |(st_r & m_up);
	assign dn_s  = |(st_r & m_dn);
	assign clr_s = |(st_r & m_clr);

	// Run command state; hold blocks two-wire restart after outside stop
	dtiom_pkg::dtiom_run_t run_r, run_nxt, cmd2w;
	logic hold_r, hold_nxt, fwd_q_r, rev_q_r, fwd_rise, rev_rise;
	assign fwd_rise = fwd_s & ~fwd_q_r;
	assign rev_rise = rev_s & ~rev_q_r;

	always_comb begin
		run_nxt  = run_r;
		hold_nxt = 1'b0;
		cmd2w    = dtiom_pkg::ST_STOP;
		if (i_mode == dtiom_pkg::MODE_2W_DIR) begin
			if (fwd_s && !rev_s) begin
				cmd2w = dtiom_pkg::ST_FWD;
			end else if (rev_s && !fwd_s) begin
				cmd2w = dtiom_pkg::ST_REV;
			end
		end else if (fwd_s) begin
			cmd2w = rev_s ? dtiom_pkg::ST_REV : dtiom_pkg::ST_FWD;
		end
		case (dtiom_pkg::dtiom_mode_t'(i_mode))
			dtiom_pkg::MODE_2W_DIR, dtiom_pkg::MODE_2W_EN: begin
				if (i_ext_stop) begin
					run_nxt  = dtiom_pkg::ST_STOP;
					hold_nxt = (cmd2w != dtiom_pkg::ST_STOP);
				end else if (hold_r) begin
					run_nxt  = dtiom_pkg::ST_STOP;
					hold_nxt = (cmd2w != dtiom_pkg::ST_STOP);
				end else begin
					run_nxt = cmd2w;
				end
			end
			dtiom_pkg::MODE_3W_DIR: begin
				if (!en_s || i_ext_stop) begin
					run_nxt = dtiom_pkg::ST_STOP;
				end else if (fwd_rise || run_r != dtiom_pkg::ST_STOP) begin
					run_nxt = rev_s ? dtiom_pkg::ST_REV : dtiom_pkg::ST_FWD;
				end
			end
			dtiom_pkg::MODE_3W_EN: begin
				if (!en_s || i_ext_stop) begin
					run_nxt = dtiom_pkg::ST_STOP;
				end else if (fwd_rise) begin
					run_nxt = dtiom_pkg::ST_FWD;
				end else if (rev_rise) begin
					run_nxt = dtiom_pkg::ST_REV;
				end
			end
			default: run_nxt = dtiom_pkg::ST_STOP;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			run_r   <= dtiom_pkg::ST_STOP;
			hold_r  <= 1'b0;
			fwd_q_r <= 1'b0;
			rev_q_r <= 1'b0;
		end else begin
			run_r   <= run_nxt;
			hold_r  <= hold_nxt;
			fwd_q_r <= fwd_s;
			rev_q_r <= rev_s;
		end
	end

	// One-hot state bits drive the pins with no decode in between
	assign o_run_fwd = run_r[1];
	assign o_run_rev = run_r[2];

	// Up/down: accumulate rate each cycle while only one of up/down is active, one 0.01 Hz step per rollover
	logic [31:0]   acc_r, acc_nxt;
	logic [FW-1:0] freq_r, freq_nxt;

	always_comb begin
		acc_nxt  = 32'h0;
		freq_nxt = freq_r;
		if (clr_s) begin
			freq_nxt = dtiom_pkg::FREQ_RST;
		end else if (up_s ^ dn_s) begin
			acc_nxt = acc_r + 32'(i_updn_rate);
			if (acc_nxt >= 32'(SEC_CYC)) begin
				acc_nxt = acc_nxt - 32'(SEC_CYC);
				if (up_s && freq_r < i_max_freq) begin
					freq_nxt = freq_r + 16'h0001;
				end else if (dn_s && freq_r != 16'h0000) begin
					freq_nxt = freq_r - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc_r  <= 32'h0;
			freq_r <= dtiom_pkg::FREQ_RST;
		end else begin
			acc_r  <= acc_nxt;
			freq_r <= freq_nxt;
		end
	end

	assign o_set_freq = freq_r;

	// Shared filter tick; one step per 0.01 s keeps the divider slow
	logic [31:0] tick_cnt_r, tick_cnt_nxt;
	logic        tick;
	assign tick = (tick_cnt_r == 32'(FILT_CYC - 1));

	always_comb begin
		tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_r <= 32'h0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end

	// Per analog input: unit conversion, filter, two-point scaling
	logic [VW-1:0] filt [2];

	for (genvar c = 0; c < 2; c++) begin : g_ain
		logic [VW-1:0]        raw, vlt, filt_r, filt_nxt;
		logic signed [VW+1:0] diff, step;
		logic [dtiom_pkg::TC_W-1:0] tc;
		logic signed [PW-1:0] set_y;

		assign raw = i_ain_level[c*VW +: VW];
		assign tc  = i_ain_filt_tc[c*dtiom_pkg::TC_W +: dtiom_pkg::TC_W];

		always_comb begin
			vlt = i_ain_current_mode[c] ? (raw >> 1) : raw;
			if (vlt > dtiom_pkg::VOLT_FULL) begin
				vlt = dtiom_pkg::VOLT_FULL;
			end
			diff     = $signed({2'b00, vlt}) - $signed({2'b00, filt_r});
			step     = diff / $signed({3'b000, tc} + 13'h0001);
			filt_nxt = filt_r;
			if (tc == '0) begin
				filt_nxt = vlt;
			end else if (tick) begin
				if (step == '0 && diff != '0) begin
					step = (diff < 0) ? -13'sh0001 : 13'sh0001;
				end
				filt_nxt = VW'(filt_r + VW'(step));
			end
		end

		always_ff @(posedge i_clk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				filt_r <= dtiom_pkg::FILT_RST;
			end else begin
				filt_r <= filt_nxt;
			end
		end

		assign filt[c] = filt_r;

		// Each channel has its own points and settings
		dtiom_scale #(.XW(PW), .YW(PW)) u_scale (
			.i_clk   (i_clk),
			.i_rst_b (i_rst_b),
			.i_x     ($signed({1'b0, filt_r})),
			.i_x_lo  ($signed({1'b0, i_ain_lo[c*VW +: VW]})),
			.i_x_hi  ($signed({1'b0, i_ain_hi[c*VW +: VW]})),
			.i_y_lo  ($signed(i_ain_lo_set[c*PW +: PW])),
			.i_y_hi  ($signed(i_ain_hi_set[c*PW +: PW])),
			.o_y     (set_y)
		);
		assign o_ain_setting[c*PW +: PW] = set_y;
	end

	// Status outputs: each selector picks one drive condition
	logic       running;
	logic [2:0] dout_r, dout_nxt;
	assign running = (run_r != dtiom_pkg::ST_STOP) && (i_out_freq != '0);

	for (genvar o = 0; o < 3; o++) begin : g_dout
		always_comb begin
			case (i_dout_sel[o*SW +: SW])
				dtiom_pkg::OSEL_FREQ:  dout_nxt[o] = i_freq_reached;
				dtiom_pkg::OSEL_DET:   dout_nxt[o] = i_det_reached;
				dtiom_pkg::OSEL_FAULT: dout_nxt[o] = i_fault;
				dtiom_pkg::OSEL_FWD:
					dout_nxt[o] = running && run_r == dtiom_pkg::ST_FWD;
				dtiom_pkg::OSEL_REV:
					dout_nxt[o] = running && run_r == dtiom_pkg::ST_REV;
				dtiom_pkg::OSEL_NULL:
					dout_nxt[o] = i_out_freq < i_start_freq;
				dtiom_pkg::OSEL_UPPER:
					dout_nxt[o] = running && i_out_freq >= i_upper_freq;
				dtiom_pkg::OSEL_LOWER:
					dout_nxt[o] = running && i_out_freq <= i_lower_freq;
				default: dout_nxt[o] = 1'b0; // None and reserved codes
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dout_r <= 3'h0;
		end else begin
			dout_r <= dout_nxt;
		end
	end

	assign o_dout = dout_r;

	// Analog output source in 0.1 % of its full scale, saturated at 100 %
	function automatic logic signed [PW-1:0] f_frac(input logic [FW-1:0] v,
			input logic [FW-1:0] full);
		logic [31:0] q;
		q = (full == '0) ? 32'h0 : (32'(v) * 32'h3e8) / 32'(full);
		f_frac = (q > 32'h3e8) ? dtiom_pkg::PCT_FULL : PW'(q);
	endfunction

	logic signed [PW-1:0] ao_pct, ao_lvl;
	logic [VW:0]          ao_r, ao_nxt;

	always_comb begin
		case (i_ao_sel)
			dtiom_pkg::AOS_SETF:   ao_pct = f_frac(freq_r, i_max_freq);
			dtiom_pkg::AOS_OPERF:  ao_pct = f_frac(i_out_freq, i_max_freq);
			// Double-rated full scale: value in 0.1 % of rated over 2000
			dtiom_pkg::AOS_CURR:   ao_pct = f_frac(i_out_current, 16'h07d0);
			dtiom_pkg::AOS_VOLT:   ao_pct = f_frac(i_out_voltage, 16'h07d0);
			dtiom_pkg::AOS_SPEED:  ao_pct = f_frac(i_speed, 16'h07d0);
			dtiom_pkg::AOS_POWER:  ao_pct = f_frac(i_power, 16'h07d0);
			dtiom_pkg::AOS_TORQUE: ao_pct = f_frac(i_torque, 16'h07d0);
			dtiom_pkg::AOS_VIN:    ao_pct = $signed({1'b0, filt[0]});
			dtiom_pkg::AOS_CIN:    ao_pct = $signed({1'b0, filt[1]});
			default:               ao_pct = '0;
		endcase
	end

	dtiom_scale #(.XW(PW), .YW(PW)) u_ao_scale (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_x     (ao_pct),
		.i_x_lo  ($signed(i_ao_lo_pct)),
		.i_x_hi  ($signed(i_ao_hi_pct)),
		.i_y_lo  ($signed({1'b0, i_ao_lo_lvl})),
		.i_y_hi  ($signed({1'b0, i_ao_hi_lvl})),
		.o_y     (ao_lvl)
	);

	// Current mode doubles the level: 0.01 V becomes 0.02 mA per count
	always_comb begin
		ao_nxt = i_ao_current_mode ? {ao_lvl[VW-1:0], 1'b0}
		                           : {1'b0, ao_lvl[VW-1:0]};
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ao_r <= '0;
		end else begin
			ao_r <= ao_nxt;
		end
	end

	assign o_analog_output = ao_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	property p_mode0_fwd;
		(run_r == dtiom_pkg::ST_FWD && $past(i_mode) == 2'h0)
			|-> $past(fwd_s && !rev_s && !i_ext_stop);
	endproperty
	a_mode0_fwd: assert property (p_mode0_fwd)
		else $error("mode 0 forward without forward input alone");

	property p_mode1_rev;
		(run_r == dtiom_pkg::ST_REV && $past(i_mode) == 2'h1)
			|-> $past(fwd_s && rev_s);
	endproperty
	a_mode1_rev: assert property (p_mode1_rev)
		else $error("mode 1 reverse without enable and direction");

	property p_3w_enable;
		(i_mode[1] && !en_s) |=> (run_r == dtiom_pkg::ST_STOP);
	endproperty
	a_3w_enable: assert property (p_3w_enable)
		else $error("three-wire run while enable open");

	property p_3w_rev_btn;
		(i_mode == 2'h3 && en_s && !i_ext_stop && !fwd_rise && rev_rise)
			|=> (run_r == dtiom_pkg::ST_REV);
	endproperty
	a_3w_rev_btn: assert property (p_3w_rev_btn)
		else $error("reverse button did not start reverse");

	property p_no_restart;
		(!i_mode[1] && i_ext_stop && cmd2w != dtiom_pkg::ST_STOP)
			##1 (!i_mode[1] && cmd2w != dtiom_pkg::ST_STOP)
			|=> (run_r == dtiom_pkg::ST_STOP);
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("two-wire restart without new run edge");

	property p_updn_step;
		!$past(clr_s) |-> (freq_r == $past(freq_r)
			|| freq_r == $past(freq_r) + 16'h0001
			|| freq_r == $past(freq_r) - 16'h0001);
	endproperty
	a_updn_step: assert property (p_updn_step)
		else $error("set frequency moved more than one step");

	property p_fault_out;
		(i_dout_sel[2*SW +: SW] == 4'h3) |=> (o_dout[2] == $past(i_fault));
	endproperty
	a_fault_out: assert property (p_fault_out)
		else $error("relay does not follow fault");

	property p_null_speed;
		(i_dout_sel[SW-1:0] == 4'h6) |=>
			(o_dout[0] == $past(i_out_freq < i_start_freq));
	endproperty
	a_null_speed: assert property (p_null_speed)
		else $error("null speed output wrong");

	property p_ao_current;
		i_ao_current_mode |=> (ao_r == {$past(ao_lvl[VW-1:0]), 1'b0});
	endproperty
	a_ao_current: assert property (p_ao_current)
		else $error("analog current level not doubled");

	c_run_fwd: cover property (run_r == dtiom_pkg::ST_FWD);
	c_run_rev: cover property (run_r == dtiom_pkg::ST_REV && i_mode[1]);
	c_updn: cover property (freq_r != $past(freq_r));
	c_relay: cover property (o_dout[2]);

endmodule

//--- testbench/dtiom_far.sv
`timescale 1ns/1ns
// Far side: contacts, buttons and whoever sets the input end points
module dtiom_far (
	input  wire logic        i_clk,
	input  wire logic [10:0] i_pt_a,
	input  wire logic [10:0] i_pt_b,
	output logic [5:0]       o_term,
	output logic [10:0]      o_lo,
	output logic [10:0]      o_hi
);
	// Points handed over in order, so a swapped pair still maps sanely
	assign o_lo = (i_pt_a < i_pt_b) ? i_pt_a : i_pt_b;
	assign o_hi = (i_pt_a < i_pt_b) ? i_pt_b : i_pt_a;

	// All contacts open at power-up
	initial begin
		o_term = 6'h00;
	end

	// Maintained switch stays where it is put
	task automatic set_sw(input int k, input logic v);
		o_term[k] = v;
	endtask

	// Momentary button springs open after n edges
	task automatic press(input int k, input int n);
		o_term[k] = 1'b1;
		repeat (n) @(posedge i_clk);
		#1 o_term[k] = 1'b0;
	endtask
endmodule

//--- testbench/dtiom_top_tb.sv
`timescale 1ns/1ns
// Bench: far-side model drives contacts and input end points, bench drives the rest
module dtiom_top_tb;
	logic        i_clk, i_rst_b, ext, fr, fd, flt, aocm, rf, rr;
	logic [1:0]  mode, aicm;
	logic [3:0]  aos;
	logic [5:0]  term;
	logic [2:0]  dout;
	logic [10:0] lv0, lv1, pa, pb, lo, hi, lol, hil;
	logic [11:0] los, his, lop, hip, dsel, ao;
	logic [15:0] mf, of, sf, uf, lf, cur, setf;
	logic [23:0] ains;
	logic [19:0] tc;
	logic [29:0] tf;
	int          n_fail, samples_checked, cyc;

	dtiom_far i_dtiom_far (.i_clk(i_clk), .i_pt_a(pa), .i_pt_b(pb),
		.o_term(term), .o_lo(lo), .o_hi(hi));
	dtiom_top #(.NTERM(6), .FILT_CYC(4), .SEC_CYC(5000)) i_dtiom_top (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_term(term),
		.i_term_func(tf),
		.i_mode(mode), .i_ext_stop(ext), .i_updn_rate(13'h1388),
		.i_max_freq(mf), .i_ain_level({lv1, lv0}),
		.i_ain_current_mode(aicm), .i_ain_lo({2{lo}}),
		.i_ain_hi({2{hi}}), .i_ain_lo_set({2{los}}),
		.i_ain_hi_set({2{his}}), .i_ain_filt_tc(tc),
		.i_freq_reached(fr), .i_det_reached(fd), .i_fault(flt),
		.i_out_freq(of), .i_start_freq(sf), .i_upper_freq(uf),
		.i_lower_freq(lf), .i_dout_sel(dsel), .i_ao_sel(aos),
		.i_ao_current_mode(aocm), .i_ao_lo_pct(lop), .i_ao_hi_pct(hip),
		.i_ao_lo_lvl(lol), .i_ao_hi_lvl(hil), .i_out_current(cur),
		.i_out_voltage(cur), .i_speed(cur), .i_power(cur),
		.i_torque(cur), .o_run_fwd(rf), .o_run_rev(rr),
		.o_set_freq(setf), .o_ain_setting(ains), .o_dout(dout),
		.o_analog_output(ao));

	// Free-running 250 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// Hang guard: the run needs well under a thousand cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// Let n edges pass, then step clear of the edge
	task automatic st(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// Compare one value and keep count
	task automatic chk(input string s, input logic [23:0] e,
		input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask

	// Set both run contacts, wait out the synchroniser, compare
	task automatic run2(input logic f, input logic r, input logic [1:0] e);
		i_dtiom_far.set_sw(0, f);
		i_dtiom_far.set_sw(1, r);
		st(8);
		chk("run", 24'(e), 24'({rr, rf}));
	endtask

	// Press one button, then compare the run state
	task automatic btn(input int k, input logic [1:0] e);
		i_dtiom_far.press(k, 6);
		st(8);
		chk("btn", 24'(e), 24'({rr, rf}));
	endtask

	// Up contact held: set frequency climbs, stops at the maximum
	task automatic t_updn();
		chk("setf", 24'h000000, 24'(setf));
		i_dtiom_far.set_sw(3, 1'b1);
		st(40);
		chk("setf", 24'h00000a, 24'(setf));
		i_dtiom_far.set_sw(3, 1'b0);
		$display("up/down done");
	endtask

	// Two-wire tables for both wiring modes
	task automatic t_two();
		run2(1'b0, 1'b0, 2'h0);
		run2(1'b1, 1'b0, 2'h1);
		run2(1'b0, 1'b1, 2'h2);
		run2(1'b1, 1'b1, 2'h0);
		mode = 2'h1;
		run2(1'b0, 1'b0, 2'h0);
		run2(1'b1, 1'b0, 2'h1);
		run2(1'b0, 1'b1, 2'h0);
		run2(1'b1, 1'b1, 2'h2);
		mode = 2'h0;
		$display("two-wire done");
	endtask

	// Outside stop while the run contact stays closed
	task automatic t_hold();
		run2(1'b1, 1'b0, 2'h1);
		ext = 1'b1;
		st(3);
		ext = 1'b0;
		run2(1'b1, 1'b0, 2'h0);
		run2(1'b0, 1'b0, 2'h0);
		run2(1'b1, 1'b0, 2'h1);
		run2(1'b0, 1'b0, 2'h0);
		$display("restart lockout done");
	endtask

	// Three-wire modes, enable on the terminal holding code 3
	task automatic t_three();
		mode = 2'h3;
		btn(0, 2'h0);
		i_dtiom_far.set_sw(2, 1'b1);
		st(8);
		btn(1, 2'h2);
		btn(0, 2'h1);
		i_dtiom_far.set_sw(2, 1'b0);
		st(8);
		chk("stop", 24'h000000, 24'({rr, rf}));
		mode = 2'h2;
		i_dtiom_far.set_sw(2, 1'b1);
		run2(1'b0, 1'b1, 2'h0);
		btn(0, 2'h2);
		run2(1'b0, 1'b0, 2'h1);
		ext = 1'b1;
		st(2);
		ext = 1'b0;
		run2(1'b0, 1'b0, 2'h0);
		i_dtiom_far.set_sw(2, 1'b0);
		// Move the enable role to terminal 4; terminal 2 loses it
		mode = 2'h3;
		tf = {5'h00, 5'h03, 5'h09, 5'h00, 5'h02, 5'h01};
		st(1);
		i_dtiom_far.set_sw(4, 1'b1);
		st(8);
		btn(1, 2'h2);
		i_dtiom_far.set_sw(4, 1'b0);
		st(8);
		chk("en", 24'h000000, 24'({rr, rf}));
		tf = {10'h000, 5'h09, 5'h03, 5'h02, 5'h01};
		mode = 2'h0;
		$display("three-wire done");
	endtask

	// Every output selector code while running forward
	task automatic t_dout();
		logic [10:0] m;
		m = 11'h0da;
		run2(1'b1, 1'b0, 2'h1);
		for (int c = 0; c < 11; c++) begin
			dsel = {3{c[3:0]}};
			st(3);
			chk("dout", 24'({3{m[c]}}), 24'(dout));
		end
		dsel = {dtiom_pkg::OSEL_NULL, dtiom_pkg::OSEL_REV,
			dtiom_pkg::OSEL_FWD};
		run2(1'b0, 1'b1, 2'h2);
		chk("dout", 24'h000006, 24'(dout));
		$display("output selectors done");
	endtask

	// Both analog inputs: scaling, clamping, current-mode halving
	task automatic ain(input logic [10:0] a, input logic [10:0] b,
		input logic [23:0] e);
		lv0 = a;
		lv1 = b;
		st(10);
		chk("ain", e, ains);
	endtask

	// Analog output: source, clamped two-point map, current mode
	task automatic aout(input logic [3:0] s, input logic [15:0] c,
		input logic m, input logic [11:0] e);
		aos = s;
		cur = c;
		aocm = m;
		st(4);
		chk("ao", 24'(e), 24'(ao));
	endtask

	// Filter on channel 0: held before the first tick, settled much later
	task automatic t_filt();
		tc = 20'h00001;
		lv0 = 11'h12c;
		st(2);
		chk("filt", {12'h000, 12'hc18}, ains);
		st(60);
		chk("filt", {12'h000, 12'hd65}, ains);
		tc = 20'h00000;
		$display("filter done");
	endtask

	// Verdict, printed once from here only
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Time-zero values, reset, then the scenarios in turn
	initial begin
		i_rst_b = 1'b0;
		{ext, fr, fd, flt, aocm} = 5'h0a;
		{mode, aicm, aos} = {2'h0, 2'h2, 4'h0};
		{pa, pb, lv0, lv1} = {11'h3e8, 11'h000, 11'h000, 11'h000};
		{lol, hil} = {11'h064, 11'h384};
		{los, his, lop, hip} = {12'hc18, 12'h3e8, 12'h064, 12'h384};
		dsel = 12'h000;
		tf = {10'h000, 5'h09, 5'h03, 5'h02, 5'h01};
		tc = 20'h00000;
		{mf, of, sf} = {16'h000a, 16'h03e8, 16'h07d0};
		{uf, lf, cur} = {16'h03e8, 16'h01f4, 16'h0000};
		st(16);
		i_rst_b = 1'b1;
		st(2);
		t_updn();
		t_two();
		t_hold();
		t_three();
		t_dout();
		ain(11'h0fa, 11'h3e8, {12'h000, 12'he0c});
		ain(11'h5dc, 11'h7d0, {12'h3e8, 12'h3e8});
		{pa, pb} = {11'h0c8, 11'h320};
		ain(11'h064, 11'h3e8, {12'h000, 12'hc18});
		t_filt();
		aout(dtiom_pkg::AOS_TORQUE, 16'h03e8, 1'b0, 12'h1f4);
		aout(dtiom_pkg::AOS_VIN, 16'h0000, 1'b0, 12'h12c);
		aout(dtiom_pkg::AOS_SETF, 16'h0000, 1'b0, 12'h384);
		aout(dtiom_pkg::AOS_CURR, 16'h07d0, 1'b0, 12'h384);
		aout(dtiom_pkg::AOS_CURR, 16'h03e8, 1'b0, 12'h1f4);
		aout(4'h9, 16'h03e8, 1'b0, 12'h064);
		aout(4'h9, 16'h03e8, 1'b1, 12'h0c8);
		$display("analog paths done");
		tally_and_finish();
	end
endmodule
